/* rtl/pbm_defines.vh */
// register indexes, field positions and timing constants of the phy basic management bank
`ifndef PBM_DEFINES_VH
`define PBM_DEFINES_VH

// register indexes
`define PBM_IDX_CONTROL 5'h00
`define PBM_IDX_STATUS 5'h01
`define PBM_IDX_ID_HIGH 5'h02
`define PBM_IDX_ID_LOW 5'h03
`define PBM_IDX_AN_ADV 5'h04
`define PBM_IDX_AN_LPA 5'h05
`define PBM_IDX_AN_EXP 5'h06
`define PBM_IDX_MODE_CS 5'h11
`define PBM_IDX_SPECIAL 5'h12
`define PBM_IDX_SPEC_IND 5'h1b
`define PBM_IDX_INT_SRC 5'h1d
`define PBM_IDX_INT_MASK 5'h1e
`define PBM_IDX_SPEC_CS 5'h1f

// control bit positions
`define PBM_CTL_RESET 15
`define PBM_CTL_LOOPBACK 14
`define PBM_CTL_SPEED 13
`define PBM_CTL_AN_EN 12
`define PBM_CTL_PWR_DOWN 11
`define PBM_CTL_AN_RESTART 9
`define PBM_CTL_DUPLEX 8
`define PBM_CTL_COL_TEST 7

// status bit positions
`define PBM_STS_T4 15
`define PBM_STS_AN_DONE 5
`define PBM_STS_RFAULT 4
`define PBM_STS_AN_ABLE 3
`define PBM_STS_LINK 2
`define PBM_STS_JABBER 1
`define PBM_STS_EXT_CAP 0

// fixed ability bits: 100 full/half, 10 full/half, an able, extended caps
`define PBM_STS_FIXED 16'h7809

// software reset count in clk_sys cycles; the reset bit stays set for one cycle more
`define PBM_SRST_CYCLES 4'h8

`endif

/* rtl/pbm_regs.v */
// management register bank of the integrated phy: control, status and first identifier
//
// Behaviour
// - registers reached only by index through management path
// - decode indexes 0-6 and 17,18,27,29,30,31
// - exempt fields survive only the software reset
// - control bit 15 starts self-clearing software reset
// - control bit 14 selects loopback, resets zero
// - bit 13 speed, ignored under auto-negotiation
// - bit 12 enables auto-negotiation, overrides speed/duplex
// - speed and an-enable reset values from strap
// - bit 11 power down; forces status 5 to zero
// - bit 9 restarts auto-negotiation, self-clearing
// - bit 8 duplex, ignored under auto-negotiation
// - bit 7 enables collision test, resets zero
// - fixed ability bits 15 zero, 14-11 one
// - status bit 5 shows auto-negotiation complete
// - status bit 4 latching-high remote fault
// - status bit 2 latching-low link status
// - status bit 1 latching-high jabber detect
// - status bits 3 and 0 read one
// - identifier one returns maker id bits
//
// notes for the next engineer
// - requests come from mac logic on clk_sys, so they pass no synchroniser
// - every answer comes one cycle after its request, reads and writes alike
// - read data holds between reads, so the mac may pick it up late
// - unknown indexes still answer, with hit low and zero data
// - known indexes outside this bank read zero, except identifier two
// - pin levels pass two flops; a pulse shorter than a cycle may be missed
// - latching flags load the live level on a status read, so an event in
//   the read cycle is kept rather than lost
// - link flag starts low after reset until the first status read
// - software reset runs a fixed count of cycles and drops control writes
//   until it is over; the mac sees no busy indication on this path
// - a reset write ignores its other bits; defaults come back afterwards
// - strap level is caught once after reset release and reused by every
//   software reset, so a strap that moves later has no effect
// - the synchroniser needs two edges to fill, so capture waits for a
//   third edge; an early strap read would always see zero
// - speed and duplex outputs read zero while auto-negotiation is on;
//   the core takes the negotiated result from elsewhere
// - status bit 5 needs auto-negotiation enabled and the phy powered
// - no exempt fields live in this bank, so a software reset clears all
// - restart and reset bits clear themselves; the mac never clears them
// - nothing here drives a pin directly; all outputs are flops
`timescale 1ns/10ps
`default_nettype none
`include "pbm_defines.vh"

module pbm_regs #(
    parameter [15:0] ID_HIGH = 16'h1234, // arbitrary neutral identifier value
    parameter [15:0] ID_LOW = 16'h5678 // arbitrary neutral identifier value
) (
    // clock and reset
    input wire clk_sys,
    input wire rstn,
    // strap pin
    input wire speed_strap,
    // management access, from mac logic on clk_sys
    input wire mgmt_req,
    input wire mgmt_write,
    input wire [4:0] mgmt_index,
    input wire [15:0] mgmt_wdata,
    output reg [15:0] mgmt_rdata,
    output reg mgmt_ack,
    output reg mgmt_hit,
    // live phy conditions, pins from the analog side
    input wire an_complete,
    input wire remote_fault,
    input wire link_up,
    input wire jabber,
    // controls to the phy core
    output reg soft_reset_busy,
    output reg loopback_en,
    output reg speed_100,
    output reg duplex_full,
    output reg an_enable,
    output reg an_restart,
    output reg power_down,
    output reg col_test_en
);

    // synchroniser stages, one pair per pin
    reg [1:0] strap_s_q;
    reg [1:0] an_s_q;
    reg [1:0] rf_s_q;
    reg [1:0] link_s_q;
    reg [1:0] jab_s_q;
    // strap capture and register state
    reg [1:0] strap_fill_q;
    reg strap_cap_q;
    reg strap_done_q;
    reg [15:0] ctl_q;
    reg [3:0] srst_cnt_q;
    reg rf_lat_q;
    reg link_lat_q;
    reg jab_lat_q;
    reg an_restart_pend_q;
    wire wr_ctl;
    wire rd_sts;
    wire srst_req;
    wire [15:0] sts_w;

    // index decode used for hit only; data select compares the index directly
    function is_known;
        input [4:0] idx;
        begin
            if (idx <= `PBM_IDX_AN_EXP) begin
                // control, status, identifiers and the negotiation registers
                is_known = 1'b1;
            end else if (idx == `PBM_IDX_MODE_CS) begin
                is_known = 1'b1;
            end else if (idx == `PBM_IDX_SPECIAL) begin
                is_known = 1'b1;
            end else if (idx == `PBM_IDX_SPEC_IND) begin
                is_known = 1'b1;
            end else if (idx == `PBM_IDX_INT_SRC) begin
                is_known = 1'b1;
            end else if (idx == `PBM_IDX_INT_MASK) begin
                is_known = 1'b1;
            end else if (idx == `PBM_IDX_SPEC_CS) begin
                is_known = 1'b1;
            end else begin
                // gaps in the index map answer with hit low
                is_known = 1'b0;
            end
        end
    endfunction

    assign wr_ctl = mgmt_req & mgmt_write & (mgmt_index == `PBM_IDX_CONTROL);
    assign rd_sts = mgmt_req & ~mgmt_write & (mgmt_index == `PBM_IDX_STATUS);
    assign srst_req = wr_ctl & mgmt_wdata[`PBM_CTL_RESET];

    // two-stage synchronisers for pin inputs
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            strap_s_q <= 2'h0;
            an_s_q <= 2'h0;
            rf_s_q <= 2'h0;
            link_s_q <= 2'h0;
            jab_s_q <= 2'h0;
        end else begin
            // strap level, only read while capturing
            strap_s_q <= {strap_s_q[0], speed_strap};
            // negotiation done level from the core
            an_s_q <= {an_s_q[0], an_complete};
            // remote fault, feeds a latching-high flag
            rf_s_q <= {rf_s_q[0], remote_fault};
            // link level, feeds a latching-low flag
            link_s_q <= {link_s_q[0], link_up};
            // jabber, feeds a latching-high flag
            jab_s_q <= {jab_s_q[0], jabber};
        end
    end

    // strap caught once after release; done only after the synchroniser has filled
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            strap_fill_q <= 2'h0;
            strap_cap_q <= 1'b0;
            strap_done_q <= 1'b0;
        end else if (!strap_done_q) begin
            // second stage holds the pin from the second edge on; capture takes it at the third
            strap_fill_q <= {strap_fill_q[0], 1'b1};
            strap_cap_q <= strap_s_q[1];
            strap_done_q <= strap_fill_q[1];
        end
    end

    // control register; speed and an-enable follow the strap up to and including the capture edge
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ctl_q <= 16'h0000;
            srst_cnt_q <= 4'h0;
            an_restart_pend_q <= 1'b0;
        end else if (strap_done_q && srst_cnt_q == 4'h0 && ctl_q[`PBM_CTL_RESET]) begin
            // software reset finishing: self-clear and restore defaults
            ctl_q <= 16'h0000;
            ctl_q[`PBM_CTL_SPEED] <= strap_cap_q;
            ctl_q[`PBM_CTL_AN_EN] <= strap_cap_q;
            an_restart_pend_q <= 1'b0;
        end else if (srst_cnt_q != 4'h0) begin
            // writes during the reset are dropped; keeps the sequence atomic
            srst_cnt_q <= srst_cnt_q - 4'h1;
        end else if (srst_req) begin
            // reset write: clear everything else and start the count
            ctl_q <= 16'h0000;
            ctl_q[`PBM_CTL_RESET] <= 1'b1;
            srst_cnt_q <= `PBM_SRST_CYCLES; // other bits ignored here
        end else if (wr_ctl) begin
            // plain write: reserved bits stay zero
            ctl_q[`PBM_CTL_LOOPBACK] <= mgmt_wdata[`PBM_CTL_LOOPBACK];
            ctl_q[`PBM_CTL_SPEED] <= mgmt_wdata[`PBM_CTL_SPEED];
            ctl_q[`PBM_CTL_AN_EN] <= mgmt_wdata[`PBM_CTL_AN_EN];
            ctl_q[`PBM_CTL_PWR_DOWN] <= mgmt_wdata[`PBM_CTL_PWR_DOWN];
            ctl_q[`PBM_CTL_AN_RESTART] <= mgmt_wdata[`PBM_CTL_AN_RESTART];
            ctl_q[`PBM_CTL_DUPLEX] <= mgmt_wdata[`PBM_CTL_DUPLEX];
            ctl_q[`PBM_CTL_COL_TEST] <= mgmt_wdata[`PBM_CTL_COL_TEST];
            an_restart_pend_q <= mgmt_wdata[`PBM_CTL_AN_RESTART];
        end else if (!strap_done_q) begin
            // follow the strap until capture is done
            ctl_q[`PBM_CTL_SPEED] <= strap_s_q[1];
            ctl_q[`PBM_CTL_AN_EN] <= strap_s_q[1];
        end else if (an_restart_pend_q) begin
            // restart pulse lasts one cycle, then the bit clears itself
            ctl_q[`PBM_CTL_AN_RESTART] <= 1'b0;
            an_restart_pend_q <= 1'b0;
        end
    end

    // latching flags: a status read re-arms them; live event wins on the read cycle
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rf_lat_q <= 1'b0;
            link_lat_q <= 1'b0;
            jab_lat_q <= 1'b0;
        end else if (soft_reset_busy) begin
            // software reset clears the latches like a power-up
            rf_lat_q <= 1'b0;
            link_lat_q <= 1'b0;
            jab_lat_q <= 1'b0;
        end else if (rd_sts) begin
            rf_lat_q <= rf_s_q[1];
            link_lat_q <= link_s_q[1];
            jab_lat_q <= jab_s_q[1];
        end else begin
            // hold the latched event until the next status read
            rf_lat_q <= rf_lat_q | rf_s_q[1];
            link_lat_q <= link_lat_q & link_s_q[1];
            jab_lat_q <= jab_lat_q | jab_s_q[1];
        end
    end

    // status word; an-done only while powered and enabled
    assign sts_w = `PBM_STS_FIXED
        | ({15'h0000, an_s_q[1] & ctl_q[`PBM_CTL_AN_EN] & ~ctl_q[`PBM_CTL_PWR_DOWN]} << `PBM_STS_AN_DONE)
        | ({15'h0000, rf_lat_q} << `PBM_STS_RFAULT)
        | ({15'h0000, link_lat_q} << `PBM_STS_LINK)
        | ({15'h0000, jab_lat_q} << `PBM_STS_JABBER);

    // management answer registered one cycle after the request
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            mgmt_rdata <= 16'h0000;
            mgmt_ack <= 1'b0;
            mgmt_hit <= 1'b0;
        end else begin
            mgmt_ack <= mgmt_req;
            mgmt_hit <= mgmt_req & is_known(mgmt_index);
            if (mgmt_req && !mgmt_write) begin
                if (mgmt_index == `PBM_IDX_CONTROL) begin
                    // reset bit reads one while the reset runs
                    mgmt_rdata <= ctl_q;
                end else if (mgmt_index == `PBM_IDX_STATUS) begin
                    // this read also re-arms the latching flags
                    mgmt_rdata <= sts_w;
                end else if (mgmt_index == `PBM_IDX_ID_HIGH) begin
                    // fixed identifier, set per build
                    mgmt_rdata <= ID_HIGH;
                end else if (mgmt_index == `PBM_IDX_ID_LOW) begin
                    // second identifier word, set per build
                    mgmt_rdata <= ID_LOW;
                end else begin
                    mgmt_rdata <= 16'h0000; // outside this bank
                end
            end
        end
    end

    // controls to the core; manual speed and duplex only without auto-negotiation
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            soft_reset_busy <= 1'b0;
            loopback_en <= 1'b0;
            speed_100 <= 1'b0;
            duplex_full <= 1'b0;
            an_enable <= 1'b0;
            an_restart <= 1'b0;
            power_down <= 1'b0;
            col_test_en <= 1'b0;
        end else begin
            // every control output lags its bit by one cycle
            soft_reset_busy <= ctl_q[`PBM_CTL_RESET];
            loopback_en <= ctl_q[`PBM_CTL_LOOPBACK];
            speed_100 <= ctl_q[`PBM_CTL_AN_EN] ? 1'b0 : ctl_q[`PBM_CTL_SPEED];
            duplex_full <= ctl_q[`PBM_CTL_AN_EN] ? 1'b0 : ctl_q[`PBM_CTL_DUPLEX];
            an_enable <= ctl_q[`PBM_CTL_AN_EN];
            an_restart <= ctl_q[`PBM_CTL_AN_RESTART];
            power_down <= ctl_q[`PBM_CTL_PWR_DOWN];
            col_test_en <= ctl_q[`PBM_CTL_COL_TEST];
        end
    end

endmodule // pbm_regs
`default_nettype wire

/* tb/pbm_regs_assertions.sv */
// assertion checker for the phy basic management bank
`timescale 1ns/10ps
`default_nettype none
module pbm_regs_assertions #(parameter [15:0] ID_HIGH = 16'h0000) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // management request and answer
    input wire logic mgmt_req,
    input wire logic mgmt_write,
    input wire logic [4:0] mgmt_index,
    input wire logic [15:0] mgmt_wdata,
    input wire logic [15:0] mgmt_rdata,
    input wire logic mgmt_ack,
    input wire logic mgmt_hit,
    // core controls
    input wire logic soft_reset_busy,
    input wire logic loopback_en,
    input wire logic speed_100,
    input wire logic duplex_full,
    input wire logic an_enable,
    input wire logic an_restart,
    input wire logic power_down,
    input wire logic col_test_en
);
    // request decode; writes inside a soft reset run are dropped, so left out
    wire known_idx = mgmt_index <= 5'h06 || mgmt_index == 5'h11 || mgmt_index == 5'h12 || mgmt_index == 5'h1b
        || mgmt_index >= 5'h1d;
    wire ctl_wr = mgmt_req && mgmt_write && mgmt_index == 5'h00 && !mgmt_wdata[15] && !soft_reset_busy;
    wire rst_wr = mgmt_req && mgmt_write && mgmt_index == 5'h00 && mgmt_wdata[15] && !soft_reset_busy;
    wire rd_req = mgmt_req && !mgmt_write;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    sequence s_restart_pulse;
        an_restart ##1 !an_restart;
    endsequence
    sequence s_srst_run;
        soft_reset_busy [*8] ##[1:6] !soft_reset_busy;
    endsequence
    AST_ACK_HIT: assert property (mgmt_req |=> mgmt_ack && mgmt_hit == $past(known_idx))
        else $error("ack or hit wrong after request");
    AST_ACK_CAUSE: assert property (mgmt_ack |-> $past(mgmt_req))
        else $error("ack without request");
    AST_FIXED: assert property (rd_req && mgmt_index == 5'h01 |=> mgmt_rdata[15:6] == 10'h1e0 && mgmt_rdata[3]
        && mgmt_rdata[0]) else $error("status fixed bits wrong");
    AST_ID: assert property (rd_req && mgmt_index == 5'h02 |=> mgmt_rdata == ID_HIGH)
        else $error("identifier wrong");
    AST_AN_OVER: assert property (an_enable |-> !speed_100 && !duplex_full)
        else $error("manual speed or duplex active under auto-negotiation");
    AST_RESTART: assert property (ctl_wr && mgmt_wdata[9] |-> ##2 s_restart_pulse)
        else $error("restart pulse missing");
    AST_SRST: assert property (rst_wr |-> ##2 s_srst_run)
        else $error("soft reset run length wrong");
    AST_MODES: assert property (ctl_wr |-> ##2 loopback_en == $past(mgmt_wdata[14], 2)
        && power_down == $past(mgmt_wdata[11], 2) && col_test_en == $past(mgmt_wdata[7], 2))
        else $error("mode outputs do not follow control write");
    AST_SPEED: assert property (ctl_wr |-> ##2 an_enable == $past(mgmt_wdata[12], 2)
        && speed_100 == $past(mgmt_wdata[13] && !mgmt_wdata[12], 2)
        && duplex_full == $past(mgmt_wdata[8] && !mgmt_wdata[12], 2)) else $error("speed or duplex wrong");
endmodule // pbm_regs_assertions
bind pbm_regs pbm_regs_assertions #(.ID_HIGH(ID_HIGH)) i_pbm_regs_assertions (.clk_sys, .rstn, .mgmt_req,
    .mgmt_write, .mgmt_index, .mgmt_wdata, .mgmt_rdata, .mgmt_ack, .mgmt_hit, .soft_reset_busy, .loopback_en,
    .speed_100, .duplex_full, .an_enable, .an_restart, .power_down, .col_test_en);
`default_nettype wire

/* tb/pbm_mac_model.sv */
// mac management path model that issues indexed accesses
`timescale 1ns/10ps
`default_nettype none
module pbm_mac_model (
    // clock
    input wire logic clk_sys,
    // request side
    output var logic mgmt_req,
    output var logic mgmt_write,
    output var logic [4:0] mgmt_index,
    output var logic [15:0] mgmt_wdata,
    // answer side
    input wire logic [15:0] mgmt_rdata,
    input wire logic mgmt_ack,
    input wire logic mgmt_hit
);
    // idle lines at time zero
    initial begin
        mgmt_req = 1'b0;
        mgmt_write = 1'b0;
        mgmt_index = 5'h00;
        mgmt_wdata = 16'h0000;
    end
    // one indexed access, called at a rising edge; registers only reached this way
    task automatic access(input logic wr, input logic [4:0] idx, input logic [15:0] wd, output logic [15:0] rd,
        output logic hit, output logic ok);
        int n;
        mgmt_req <= 1'b1;
        mgmt_write <= wr;
        mgmt_index <= idx;
        mgmt_wdata <= wd;
        @(posedge clk_sys);
        // released index and data lines are scrambled so a stale value never passes
        mgmt_req <= 1'b0;
        mgmt_index <= ~idx;
        mgmt_wdata <= ~wd;
        n = 0;
        while (mgmt_ack !== 1'b1 && n < 4) begin
            @(posedge clk_sys);
            n++;
        end
        rd = mgmt_rdata;
        hit = mgmt_hit;
        ok = (mgmt_ack === 1'b1);
    endtask
endmodule // pbm_mac_model
`default_nettype wire

/* tb/pbm_regs_tb.sv */
// self-checking bench for the phy basic management bank
`timescale 1ns/10ps
`default_nettype none
module pbm_regs_tb;
    localparam logic [15:0] ID_HIGH = 16'h2c4a; // arbitrary neutral value
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic speed_strap = 1'b1;
    logic an_complete = 1'b0, remote_fault = 1'b0, link_up = 1'b0, jabber = 1'b0;
    wire logic mgmt_req, mgmt_write, mgmt_ack, mgmt_hit;
    wire logic [4:0] mgmt_index;
    wire logic [15:0] mgmt_wdata, mgmt_rdata;
    logic [15:0] rd, wd;
    logic hit, ok;
    int miscompares = 0, total_checks = 0;
    pbm_regs #(.ID_HIGH(ID_HIGH)) i_pbm_regs (.clk_sys, .rstn, .speed_strap, .mgmt_req, .mgmt_write, .mgmt_index,
        .mgmt_wdata, .mgmt_rdata, .mgmt_ack, .mgmt_hit, .an_complete, .remote_fault, .link_up, .jabber,
        .soft_reset_busy(), .loopback_en(), .speed_100(), .duplex_full(), .an_enable(), .an_restart(),
        .power_down(), .col_test_en());
    pbm_mac_model i_pbm_mac_model (.clk_sys, .mgmt_req, .mgmt_write, .mgmt_index, .mgmt_wdata, .mgmt_rdata,
        .mgmt_ack, .mgmt_hit);
    always #25 clk_sys = ~clk_sys;
    task automatic close_out;
        if (miscompares == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask
    // access plus ack check; a missing ack is counted at once
    task automatic acc(input logic wr, input logic [4:0] idx, input logic [15:0] d);
        i_pbm_mac_model.access(wr, idx, d, rd, hit, ok);
        chk("ack", 16'h0001, {15'h0000, ok});
    endtask
    function automatic logic [15:0] exp_sts(input logic an, rf, lk, jb);
        return 16'h7809 | {10'h000, an, rf, 1'b0, lk, jb, 1'b0};
    endfunction
    function automatic logic exp_known(input logic [4:0] i);
        return i <= 5'h06 || i == 5'h11 || i == 5'h12 || i == 5'h1b || i >= 5'h1d;
    endfunction
    // watchdog well beyond the expected run of under a thousand cycles
    initial begin
        #(4000 * 50);
        miscompares++;
        close_out;
    end
    initial begin
        void'($urandom(32'h9f68));
        repeat (6) @(posedge clk_sys);
        rstn <= 1'b1;
        repeat (4) @(posedge clk_sys);
        acc(1'b0, 5'h00, 16'h0000);
        chk("control reset", 16'h3000, rd);
        acc(1'b0, 5'h02, 16'h0000);
        chk("identifier", ID_HIGH, rd);
        for (int i = 0; i < 32; i++) begin
            acc(1'b0, i[4:0], 16'h0000);
            chk("hit", {15'h0000, exp_known(i[4:0])}, {15'h0000, hit});
        end
        // corner values first, then random control words
        for (int k = 0; k < 14; k++) begin
            wd = (k == 0) ? 16'h7fff : (k == 1) ? 16'h0000 : 16'h7fff & $urandom();
            acc(1'b1, 5'h00, wd);
            acc(1'b0, 5'h00, 16'h0000);
            chk("control", wd & 16'h7980, rd);
        end
        acc(1'b1, 5'h00, 16'h1000);
        acc(1'b1, 5'h01, 16'hffff);
        an_complete <= 1'b1;
        link_up <= 1'b1;
        repeat (4) @(posedge clk_sys);
        acc(1'b0, 5'h01, 16'h0000);
        acc(1'b0, 5'h01, 16'h0000);
        chk("status", exp_sts(1'b1, 1'b0, 1'b1, 1'b0), rd);
        acc(1'b1, 5'h00, 16'h1800);
        acc(1'b0, 5'h01, 16'h0000);
        chk("status power down", exp_sts(1'b0, 1'b0, 1'b1, 1'b0), rd);
        acc(1'b1, 5'h00, 16'h1000);
        jabber <= 1'b1;
        remote_fault <= 1'b1;
        link_up <= 1'b0;
        repeat (4) @(posedge clk_sys);
        jabber <= 1'b0;
        remote_fault <= 1'b0;
        link_up <= 1'b1;
        repeat (4) @(posedge clk_sys);
        acc(1'b0, 5'h01, 16'h0000);
        chk("status latched", exp_sts(1'b1, 1'b1, 1'b0, 1'b1), rd);
        acc(1'b0, 5'h01, 16'h0000);
        chk("status rearmed", exp_sts(1'b1, 1'b0, 1'b1, 1'b0), rd);
        // soft reset with other bits zero; the write inside the run must be dropped
        acc(1'b1, 5'h00, 16'h4100);
        acc(1'b1, 5'h00, 16'h8000);
        acc(1'b0, 5'h00, 16'h0000);
        chk("reset bit", 16'h8000, rd & 16'h8000);
        acc(1'b1, 5'h00, 16'h4000);
        repeat (12) @(posedge clk_sys);
        acc(1'b0, 5'h00, 16'h0000);
        chk("control after soft reset", 16'h3000, rd);
        close_out;
    end
endmodule // pbm_regs_tb
`default_nettype wire
